// >>> core/sess_ctrl_consts.vh
// Purpose: constants of the session control command handler
// Assumes: little-endian request byte stream, one byte per beat
// Notes: offsets are byte offsets inside the request
`ifndef SESS_CTRL_CONSTS_VH
`define SESS_CTRL_CONSTS_VH

`define HDR_LEN 7'h10
`define FLF_LEGACY_LEN 7'h38
`define HOLD_DEPTH 72
`define OPC_SHIFT 8
`define OPER_CREATE 8'h02
`define OPER_DESTROY 8'h03
`define SVC_CIPHER 2'h0
`define SVC_HASH 2'h1
`define SVC_MAC 2'h2
`define SVC_AEAD 2'h3
`define FLF_DESTROY_LEN 7'h08
`define FLF_HASH_LEN 7'h08
`define FLF_MAC_LEN 7'h10
`define FLF_SYM_LEN 7'h38
`define FLF_AEAD_LEN 7'h18
`define SYM_AREA_LEN 7'h30
`define CHAIN_SPEC_LEN 7'h10
`define OFS_OPCODE 7'h00
`define OFS_MAC_KEYLEN 7'h18
`define OFS_CIPH_KEYLEN 7'h14
`define OFS_CIPH_DIR 7'h18
`define OFS_SYM_OPTYPE 7'h40
`define OFS_CH_ORDER 7'h10
`define OFS_CH_HMODE 7'h14
`define OFS_CH_KEYLEN 7'h1c
`define OFS_CH_DIR 7'h20
`define OFS_CH_AUTHLEN 7'h30
`define OFS_AEAD_KEYLEN 7'h14
`define OFS_AEAD_DIR 7'h20
`define OPTYPE_CIPHER 32'h0000_0001
`define OPTYPE_CHAIN 32'h0000_0002
`define DIR_ENCRYPT 32'h0000_0001
`define DIR_DECRYPT 32'h0000_0002
`define ORDER_HASH_FIRST 32'h0000_0001
`define ORDER_CIPHER_FIRST 32'h0000_0002
`define HMODE_PLAIN 32'h0000_0001
`define HMODE_AUTH 32'h0000_0002
`define HMODE_NESTED 32'h0000_0003
`define ST_OK 8'h00
`define ST_ERR 8'h01
`define ST_BADMSG 8'h02
`define ST_NOTSUPP 8'h03
`define ST_INVSESS 8'h04
`define ST_NOSPC 8'h05
`define CREATE_OUT_LEN 5'h10
`define DESTROY_OUT_LEN 5'h01
`define STATUS_BYTE_POS 5'h08

`endif

// >>> core/sess_ctrl.v
// Purpose: control-queue session create/destroy command handler
// Assumes: request arrives as a byte stream ending with req_last;
//    outcome leaves as a byte stream with out_we marking assigned bytes
// Notes: the crypto algorithms themselves are outside this block
// Contract
// - create outcome: handle le64, status le32, pad
// - destroy reads le64 handle, answers one byte
// - hash params: algorithm, digest length
// - mac params add key length, key bytes
// - symmetric create is cipher or chained
// - cipher params with direction encrypt/decrypt
// - chain order selects hash or cipher first
// - hash mode selects embedded parameter meaning
// - embedded area sixteen bytes, rest ignored
// - chain keys: cipher then authentication key
// - symmetric area 48 bytes, type selects layout
// - aead params field order, then key
// - opcode selects layouts for parameter extraction
// - create reports ok, unsupported, no-space, error
// - no-space only with revision one feature
// - handle written only on success
// - destroy reports success or generic error; code also reports unsupported for an unknown service
// - status codes zero through five
// - opcode is service shifted eight or operation
// - legacy fixed area padded to 56
`timescale 1ns/1ps
`include "sess_ctrl_consts.vh"

module sess_ctrl #(
   parameter NUM_HANDLES = 16,
   parameter HW = 4
) (
   input wire mclk,
   input wire arst_n,
   input wire revision_one_feature,
   input wire [3:0] service_enable,
   input wire req_valid,
   input wire [7:0] req_byte,
   input wire req_last,
   output reg req_ready,
   output reg out_valid,
   output reg [7:0] out_byte,
   output reg out_we,
   output reg out_last,
   input wire out_ready,
   output reg [7:0] last_status,
   output reg busy
);

   localparam S_COLLECT = 3'h0;
   localparam S_CALC = 3'h1;
   localparam S_SKIP = 3'h2;
   localparam S_DECIDE = 3'h3;
   localparam S_OUT = 3'h4;

   reg [2:0] st_r;
   reg [6:0] cnt_r;
   reg [31:0] rem_r;
   reg early_r;
   reg [7:0] hold_r [0:`HOLD_DEPTH-1];
   reg [NUM_HANDLES-1:0] used_r;
   reg [1:0] owner_r [0:NUM_HANDLES-1];
   reg [7:0] status_r;
   reg [63:0] handle_r;
   reg is_create_r;
   reg [4:0] ocnt_r;

   // little-endian 32-bit field out of the held bytes
   function [31:0] fld;
      input [6:0] ofs;
      begin
         fld = {hold_r[ofs+7'h3], hold_r[ofs+7'h2], hold_r[ofs+7'h1], hold_r[ofs]};
      end
   endfunction

   wire [31:0] opcode = fld(`OFS_OPCODE);
   wire [7:0] oper = opcode[7:0];
   wire [23:0] svc_full = opcode[31:`OPC_SHIFT];
   wire [1:0] svc = svc_full[1:0];
   wire svc_known = (svc_full[23:2] == 22'h0) && service_enable[svc];
   wire is_create = (oper == `OPER_CREATE);
   wire is_destroy = (oper == `OPER_DESTROY);

   reg [6:0] flf_len;
   always @* begin
      flf_len = `FLF_DESTROY_LEN;
      if (is_create) begin
         case (svc)
            `SVC_HASH: flf_len = `FLF_HASH_LEN;
            `SVC_MAC: flf_len = `FLF_MAC_LEN;
            `SVC_CIPHER: flf_len = `FLF_SYM_LEN;
            default: flf_len = `FLF_AEAD_LEN;
         endcase
      end
      if (!revision_one_feature)
         flf_len = `FLF_LEGACY_LEN;
   end
   wire [6:0] fixed_end = `HDR_LEN + flf_len;

   wire [31:0] optype = fld(`OFS_SYM_OPTYPE);
   wire [31:0] hmode = fld(`OFS_CH_HMODE);
   // auth mode reads embedded area as mac params
   wire ch_auth = (hmode == `HMODE_AUTH);

   // variable layout from opcode and type
   reg [31:0] vlf_len;
   always @* begin
      vlf_len = 32'h0;
      if (is_create && svc_known) begin
         case (svc)
            `SVC_MAC: vlf_len = fld(`OFS_MAC_KEYLEN);
            `SVC_AEAD: vlf_len = fld(`OFS_AEAD_KEYLEN);
            `SVC_CIPHER: begin
               if (optype == `OPTYPE_CIPHER)
                  vlf_len = fld(`OFS_CIPH_KEYLEN);
               else if (optype == `OPTYPE_CHAIN)
                  // cipher key length always read, auth length only in auth mode; cipher key then auth key
                  vlf_len = fld(`OFS_CH_KEYLEN) + (ch_auth ? fld(`OFS_CH_AUTHLEN) : 32'h0);
            end
            default: vlf_len = 32'h0;
         endcase
      end
   end

   function dir_ok;
      input [31:0] d;
      begin
         dir_ok = (d == `DIR_ENCRYPT) || (d == `DIR_DECRYPT);
      end
   endfunction

   reg params_ok;
   always @* begin
      params_ok = 1'b1;
      case (svc)
         `SVC_CIPHER: begin
            if (optype == `OPTYPE_CIPHER)
               params_ok = dir_ok(fld(`OFS_CIPH_DIR));
            else if (optype == `OPTYPE_CHAIN)
               params_ok = dir_ok(fld(`OFS_CH_DIR)) &&
                  ((fld(`OFS_CH_ORDER) == `ORDER_HASH_FIRST) ||
                   (fld(`OFS_CH_ORDER) == `ORDER_CIPHER_FIRST)) &&
                  ((hmode == `HMODE_PLAIN) || ch_auth || (hmode == `HMODE_NESTED));
            else
               params_ok = 1'b0;
         end
         `SVC_AEAD: params_ok = dir_ok(fld(`OFS_AEAD_DIR));
         default: params_ok = 1'b1;
      endcase
   end

   // lowest free handle
   reg [HW-1:0] free_idx;
   reg free_any;
   integer i;
   always @* begin
      free_idx = {HW{1'b0}};
      free_any = 1'b0;
      for (i = NUM_HANDLES - 1; i >= 0; i = i - 1) begin
         if (!used_r[i]) begin
            free_idx = i[HW-1:0];
            free_any = 1'b1;
         end
      end
   end

   wire [63:0] req_handle = {fld(`HDR_LEN + 7'h4), fld(`HDR_LEN)};
   wire [HW-1:0] req_idx = req_handle[HW-1:0];
   wire handle_live = (req_handle[63:HW] == {(64-HW){1'b0}}) &&
      (req_handle < NUM_HANDLES) && used_r[req_idx] && (owner_r[req_idx] == svc);

   // decision made once the whole request is in
   reg [7:0] dec_status;
   always @* begin
      dec_status = `ST_ERR;
      if (early_r)
         dec_status = `ST_ERR;
      else if (!svc_known || !(is_create || is_destroy))
         dec_status = `ST_NOTSUPP;
      else if (is_destroy)
         dec_status = handle_live ? `ST_OK : `ST_ERR;
      else if (!params_ok)
         dec_status = `ST_NOTSUPP;
      else if (!free_any)
         dec_status = revision_one_feature ? `ST_NOSPC : `ST_ERR;
      else
         dec_status = `ST_OK;
   end

   wire take = req_valid && req_ready;
   wire [4:0] out_len = is_create_r ? `CREATE_OUT_LEN : `DESTROY_OUT_LEN;

   // outcome byte at position p
   reg [7:0] ob;
   reg owe;
   always @* begin
      ob = 8'h0;
      owe = 1'b1;
      if (!is_create_r)
         ob = status_r;
      else if (ocnt_r < `STATUS_BYTE_POS) begin
         owe = (status_r == `ST_OK);
         ob = handle_r[{ocnt_r[2:0], 3'h0} +: 8];
      end else if (ocnt_r == `STATUS_BYTE_POS)
         ob = status_r;
      else if (ocnt_r > `STATUS_BYTE_POS + 5'h3)
         owe = 1'b0;
   end

   // handle table, one slot per entry
   wire do_set = (st_r == S_DECIDE) && is_create && (dec_status == `ST_OK);
   wire do_clr = (st_r == S_DECIDE) && is_destroy && (dec_status == `ST_OK);
   genvar g;
   generate
      for (g = 0; g < NUM_HANDLES; g = g + 1) begin : slot
         always @(posedge mclk or negedge arst_n) begin
            if (!arst_n) begin
               used_r[g] <= 1'b0;
               owner_r[g] <= 2'h0;
            end else if (do_set && (free_idx == g)) begin
               used_r[g] <= 1'b1;
               owner_r[g] <= svc;
            end else if (do_clr && (req_idx == g)) begin
               used_r[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // held bytes: no reset needed, only read after being written
   always @(posedge mclk) begin
      if (take && (st_r == S_COLLECT) && (cnt_r < `HOLD_DEPTH))
         hold_r[cnt_r] <= req_byte;
   end

   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= S_COLLECT;
         cnt_r <= 7'h0;
         rem_r <= 32'h0;
         early_r <= 1'b0;
         status_r <= `ST_OK;
         handle_r <= 64'h0;
         is_create_r <= 1'b0;
         ocnt_r <= 5'h0;
         req_ready <= 1'b0;
         out_valid <= 1'b0;
         out_byte <= 8'h0;
         out_we <= 1'b0;
         out_last <= 1'b0;
         last_status <= `ST_OK;
         busy <= 1'b0;
      end else begin
         case (st_r)
            S_COLLECT: begin
               req_ready <= 1'b1;
               if (take) begin
                  busy <= 1'b1;
                  cnt_r <= cnt_r + 7'h1;
                  if ((cnt_r >= `HDR_LEN - 7'h1) && (cnt_r + 7'h1 == fixed_end)) begin
                     st_r <= S_CALC;
                     req_ready <= 1'b0;
                  end else if (req_last) begin
                     early_r <= 1'b1;
                     st_r <= S_DECIDE;
                     req_ready <= 1'b0;
                  end
               end
            end
            S_CALC: begin
               rem_r <= vlf_len;
               if (vlf_len == 32'h0 || early_r) begin
                  st_r <= S_DECIDE;
               end else begin
                  st_r <= S_SKIP;
                  req_ready <= 1'b1;
               end
            end
            S_SKIP: begin
               // key bytes are consumed; algorithms live elsewhere
               if (take) begin
                  rem_r <= rem_r - 32'h1;
                  if (rem_r == 32'h1 || req_last) begin
                     early_r <= (rem_r != 32'h1);
                     st_r <= S_DECIDE;
                     req_ready <= 1'b0;
                  end
               end
            end
            S_DECIDE: begin
               status_r <= dec_status;
               last_status <= dec_status;
               handle_r <= {{(64-HW){1'b0}}, free_idx};
               is_create_r <= ~is_destroy;
               ocnt_r <= 5'h0;
               st_r <= S_OUT;
            end
            S_OUT: begin
               if (!out_valid || out_ready) begin
                  if (out_valid && out_last) begin
                     out_valid <= 1'b0;
                     out_last <= 1'b0;
                     out_we <= 1'b0;
                     cnt_r <= 7'h0;
                     early_r <= 1'b0;
                     busy <= 1'b0;
                     st_r <= S_COLLECT;
                  end else begin
                     out_valid <= 1'b1;
                     out_byte <= ob;
                     out_we <= owe;
                     out_last <= (ocnt_r + 5'h1 == out_len);
                     ocnt_r <= ocnt_r + 5'h1;
                  end
               end
            end
            default: st_r <= S_COLLECT;
         endcase
      end
   end

endmodule // sess_ctrl

// >>> tb/sess_ctrl_monitor.sv
// Purpose: port checker for the session command handler
// Assumes: one clock, async active-low reset
// Notes: outcome position counted from bytes taken
`timescale 1ns/1ps
module sess_ctrl_monitor (
   input wire mclk,
   input wire arst_n,
   input wire req_ready,
   input wire out_valid,
   input wire [7:0] out_byte,
   input wire out_we,
   input wire out_last,
   input wire out_ready,
   input wire [7:0] last_status
);
   reg [4:0] ocnt_r;
   reg hwe_r;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ocnt_r <= 5'h00;
         hwe_r <= 1'b0;
      end else if (out_valid && out_ready) begin
         ocnt_r <= out_last ? 5'h00 : ocnt_r + 5'h01;
         if (ocnt_r == 5'h00) begin
            hwe_r <= out_we;
         end
      end
   end
   a_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_byte)
      && $stable(out_we) && $stable(out_last)) else $error("outcome byte moved before taken");
   a_ready_refused: assert property (out_valid |-> !req_ready) else $error("ready during outcome");
   a_status_range: assert property (last_status <= 8'h05) else $error("status out of range");
   a_pad_untouched: assert property (out_valid && ocnt_r >= 5'h0c |-> !out_we)
      else $error("padding written");
   a_status_fill: assert property (out_valid && ocnt_r > 5'h08 && ocnt_r < 5'h0c
      |-> out_we && out_byte == 8'h00) else $error("status upper bytes wrong");
   a_handle_ok: assert property (out_valid && ocnt_r == 5'h08
      |-> (out_byte == 8'h00) == hwe_r) else $error("handle written on failure");
   a_out_len: assert property (out_valid && out_last |-> ocnt_r == 5'h0f || ocnt_r == 5'h00)
      else $error("outcome length wrong");
   a_answer_bound: assert property ($fell(req_ready) ##1 !req_ready |-> ##[0:2] out_valid)
      else $error("no outcome after request");
endmodule // sess_ctrl_monitor
bind sess_ctrl sess_ctrl_monitor u_mon (.mclk(mclk), .arst_n(arst_n), .req_ready(req_ready),
   .out_valid(out_valid), .out_byte(out_byte), .out_we(out_we), .out_last(out_last),
   .out_ready(out_ready), .last_status(last_status));

// >>> tb/req_driver.sv
// Purpose: requester model streaming one request and draining its outcome
// Assumes: request image preloaded into mem
// Notes: released data line shows inverted byte, never the stale one
`timescale 1ns/1ps
module req_driver (
   input wire mclk,
   input wire arst_n,
   input wire go,
   input wire [6:0] len,
   input wire slow,
   input wire req_ready,
   input wire out_valid,
   input wire [7:0] out_byte,
   input wire out_we,
   input wire out_last,
   output reg req_valid,
   output reg [7:0] req_byte,
   output reg req_last,
   output reg out_ready,
   output reg done
);
   reg [7:0] mem [0:127];
   reg [7:0] got [0:15];
   reg gwe [0:15];
   reg [6:0] idx;
   reg [4:0] oi;
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         req_valid <= 1'b0;
         req_byte <= 8'h00;
         req_last <= 1'b0;
         out_ready <= 1'b0;
         done <= 1'b0;
         idx <= 7'h00;
         oi <= 5'h00;
      end else begin
         done <= 1'b0;
         if (go) begin
            idx <= 7'h00;
            oi <= 5'h00;
            req_valid <= 1'b1;
            req_byte <= mem[0];
            req_last <= len == 7'h01;
         end else if (req_valid && req_ready) begin
            idx <= idx + 7'h01;
            req_byte <= (idx + 7'h01 == len) ? ~req_byte : mem[idx + 7'h01];
            req_last <= idx + 7'h02 == len;
            req_valid <= idx + 7'h01 != len;
         end
         // slow mode stalls every other cycle
         out_ready <= slow ? ~out_ready : 1'b1;
         if (out_valid && out_ready) begin
            got[oi[3:0]] <= out_byte;
            gwe[oi[3:0]] <= out_we;
            oi <= oi + 5'h01;
            done <= out_last;
         end
      end
   end
endmodule // req_driver

// >>> tb/tb_top.sv
// Purpose: directed session create/destroy tests
// Assumes: four handles so the table fills quickly
// Notes: chain sessions use empty keys
`timescale 1ns/1ps
`include "sess_ctrl_consts.vh"
module tb_top;
   reg mclk, arst_n, rev1, go, slow, seen_busy;
   reg [3:0] svc_en;
   reg [6:0] len;
   wire req_valid, req_last, req_ready, out_valid, out_we, out_last, out_ready, busy, done;
   wire [7:0] req_byte, out_byte, last_status;
   integer mismatches, tests_run, i, j, k, m;
   sess_ctrl #(.NUM_HANDLES(4), .HW(2)) u_dut (.mclk(mclk), .arst_n(arst_n),
      .revision_one_feature(rev1), .service_enable(svc_en), .req_valid(req_valid),
      .req_byte(req_byte), .req_last(req_last), .req_ready(req_ready), .out_valid(out_valid),
      .out_byte(out_byte), .out_we(out_we), .out_last(out_last), .out_ready(out_ready),
      .last_status(last_status), .busy(busy));
   req_driver u_drv (.mclk(mclk), .arst_n(arst_n), .go(go), .len(len), .slow(slow),
      .req_ready(req_ready), .out_valid(out_valid), .out_byte(out_byte), .out_we(out_we),
      .out_last(out_last), .req_valid(req_valid), .req_byte(req_byte), .req_last(req_last),
      .out_ready(out_ready), .done(done));
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   task conclude;
      begin
         $display("compares %0d mismatches %0d", tests_run, mismatches);
         if (mismatches == 0 && tests_run > 0) $display("NO MISMATCHES");
         else $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   task chk(input string nm, input [7:0] e, input [7:0] g);
      begin
         tests_run = tests_run + 1;
         if (g !== e) begin
            mismatches = mismatches + 1;
            $display("Error %s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   task put(input [6:0] a, input [31:0] v);
      for (k = 0; k < 4; k = k + 1) u_drv.mem[a + k] = v[8*k +: 8];
   endtask
   task hdr(input [1:0] s, input [7:0] op);
      begin
         for (k = 0; k < 128; k = k + 1) u_drv.mem[k] = 8'h00;
         put(`OFS_OPCODE, ({30'h0, s} << `OPC_SHIFT) | {24'h0, op});
      end
   endtask
   task run(input [6:0] n);
      begin
         @(posedge mclk);
         len <= n;
         go <= 1'b1;
         @(posedge mclk);
         go <= 1'b0;
         j = 0;
         seen_busy = 1'b0;
         while (done !== 1'b1 && j < 600) begin
            @(negedge mclk);
            j = j + 1;
            if (busy === 1'b1) seen_busy = 1'b1;
         end
         chk("completion", 8'h01, {7'h0, done});
         chk("busy_seen", 8'h01, {7'h0, seen_busy});
         chk("busy_idle", 8'h00, {7'h0, busy});
         $display("test ended status %h", last_status);
      end
   endtask
   task create(input [6:0] n, input [7:0] st, input [7:0] h);
      begin
         run(n);
         chk("status", st, u_drv.got[8]);
         chk("last_status", st, last_status);
         chk("handle_we", {7'h0, st == `ST_OK}, {7'h0, u_drv.gwe[0]});
         if (st == `ST_OK) chk("handle", h, u_drv.got[0]);
         chk("pad_we", 8'h00, {7'h0, u_drv.gwe[12]});
      end
   endtask
   task destroy(input [1:0] s, input [7:0] h, input [7:0] st);
      begin
         hdr(s, `OPER_DESTROY);
         put(7'h10, {24'h0, h});
         run(7'h18);
         chk("destroy_status", st, u_drv.got[0]);
         chk("destroy_last_status", st, last_status);
         chk("destroy_len", 8'h01, {3'h0, u_drv.oi});
      end
   endtask
   task ciph(input [31:0] d);
      begin
         hdr(`SVC_CIPHER, `OPER_CREATE);
         put(`OFS_SYM_OPTYPE, `OPTYPE_CIPHER);
         put(`OFS_CIPH_KEYLEN, 32'h2);
         put(`OFS_CIPH_DIR, d);
      end
   endtask
   initial begin
      #200000;
      mismatches = mismatches + 1;
      conclude;
   end
   initial begin
      arst_n = 1'b0;
      rev1 = 1'b1;
      go = 1'b0;
      slow = 1'b0;
      svc_en = 4'hf;
      len = 7'h00;
      mismatches = 0;
      tests_run = 0;
      repeat (4) @(posedge mclk);
      arst_n <= 1'b1;
      repeat (2) @(posedge mclk);
      hdr(`SVC_HASH, `OPER_CREATE);
      put(7'h14, 32'h20);
      create(7'h18, `ST_OK, 8'h00);
      hdr(`SVC_MAC, `OPER_CREATE);
      put(`OFS_MAC_KEYLEN, 32'h4);
      slow = 1'b1;
      create(7'h24, `ST_OK, 8'h01);
      slow = 1'b0;
      ciph(`DIR_ENCRYPT);
      create(7'h4a, `ST_OK, 8'h02);
      ciph(32'h3);
      create(7'h4a, `ST_NOTSUPP, 8'h00);
      hdr(`SVC_AEAD, `OPER_CREATE);
      put(`OFS_AEAD_DIR, `DIR_DECRYPT);
      create(7'h28, `ST_OK, 8'h03);
      hdr(`SVC_HASH, `OPER_CREATE);
      create(7'h18, `ST_NOSPC, 8'h00);
      rev1 <= 1'b0;
      create(7'h48, `ST_ERR, 8'h00);
      rev1 <= 1'b1;
      create(7'h14, `ST_ERR, 8'h00);
      destroy(`SVC_HASH, 8'h00, `ST_OK);
      destroy(`SVC_HASH, 8'h00, `ST_ERR);
      svc_en <= 4'hd;
      hdr(`SVC_HASH, `OPER_CREATE);
      create(7'h18, `ST_NOTSUPP, 8'h00);
      svc_en <= 4'hf;
      for (i = 1; i < 3; i = i + 1) begin
         for (m = 1; m < 4; m = m + 1) begin
            hdr(`SVC_CIPHER, `OPER_CREATE);
            put(`OFS_SYM_OPTYPE, `OPTYPE_CHAIN);
            put(`OFS_CH_ORDER, i[31:0]);
            put(`OFS_CH_HMODE, m[31:0]);
            put(`OFS_CH_DIR, `DIR_DECRYPT);
            put(7'h34, 32'hffff_ffff);
            create(7'h48, `ST_OK, 8'h00);
            destroy(`SVC_CIPHER, 8'h00, `ST_OK);
         end
      end
      conclude;
   end
endmodule // tb_top
